// ==== sfr_fastlock_reset_control.sv ====
`timescale 1ns/10ps
// Function
// - Precision bit 0: denominator is the low 12 bits, upper ten ignored.
// - Precision bit 1: upper and lower fields form a 22-bit denominator.
// - Time-out codes 0 to 3: timed fastlock off, pin is general tri-state output.
// - Time-out codes 4 to 16383: timed fastlock on, pin shows fastlock.
// - Timed fastlock lasts twice the code in comparison cycles, then ends.
// - Code 0 floats, 1 low plus forced fastlock, 2 low, 3 high.
// - Fastlock pump gain field 0 to 15 gives multiples 1X to 16X.
// - Slip code 0 off; 1, 2, 3 reduce sample rate to 1/2, 1/4, 1/16.
// - Quarter-rate bit divides main lock-detect rate by 4; aux untouched.
// - Aux clear bit holds aux counters in reset and floats its pump.
// - Main clear bit holds main counters in reset and floats its pump.
// - Power-up by software or enable pin applies a counter reset.
// - Main float bit floats main pump, counters keep running.
module sfr_fastlock_reset_control #(
  parameter int WORD_W = 24
) (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic ser_clk_in,
  input wire logic ser_data_in,
  input wire logic ser_latch_in,
  input wire logic chip_enable_in,
  input wire logic soft_powerup_in,
  input wire logic main_comp_tick_in,
  input wire logic aux_comp_tick_in,
  input wire logic precision_sel_in,
  input wire logic [sfr_pkg::DEN_LO_W-1:0] den_lo_in,
  input wire logic [sfr_pkg::DEN_HI_W-1:0] den_hi_in,
  output logic [sfr_pkg::DEN_W-1:0] main_fraction_denominator_out,
  output logic fastlock_active_out,
  output logic fastlock_force_out,
  output logic fastlock_pin_out,
  output logic fastlock_pin_oe_n_out,
  output logic [4:0] pump_gain_mult_out,
  output logic [2:0] slip_div_log2_out,
  output logic main_ld_tick_out,
  output logic aux_ld_tick_out,
  output logic main_counters_reset_out,
  output logic main_pump_tristate_out,
  output logic aux_counters_reset_out,
  output logic aux_pump_tristate_out
);
  logic [WORD_W-1:0] rx_word;
  logic rx_valid;
  sfr_pkg::sfr_fastlock_t fl_cfg_ff;
  sfr_pkg::sfr_loop_reset_t lr_cfg_ff;
  logic fl_active_ff;
  logic [sfr_pkg::PERIOD_W-1:0] remain_ff;
  logic [1:0] qdiv_ff;
  logic [2:0] ce_sync_ff;
  logic powerup_clear_ff;
  logic pin_level_ff;
  logic pin_oe_n_ff;

  // Slip code to a power-of-two rate divisor
  function automatic logic [2:0] slip_log2(input logic [1:0] code);
    case (code)
      2'h0: slip_log2 = 3'h0;
      2'h1: slip_log2 = 3'h1;
      2'h2: slip_log2 = 3'h2;
      default: slip_log2 = 3'h4;
    endcase
  endfunction : slip_log2

  sfr_serial_rx #(
    .WORD_W(WORD_W)
  ) u_rx (
    .clock_in(clock_in),
    .resetn_in(resetn_in),
    .ser_clk_in(ser_clk_in),
    .ser_data_in(ser_data_in),
    .ser_latch_in(ser_latch_in),
    .word_out(rx_word),
    .word_valid_out(rx_valid)
  );

  // Address decode of the latched word
  wire [3:0] rx_addr = rx_word[sfr_pkg::ADDR_W-1:0];
  wire wr_fastlock = rx_valid && (rx_addr == sfr_pkg::ADDR_FASTLOCK);
  wire wr_loop_reset = rx_valid && (rx_addr == sfr_pkg::ADDR_LOOP_RESET);
  wire [13:0] new_toc = rx_word[sfr_pkg::TOC_LSB +: sfr_pkg::TOC_W];
  wire new_timed = new_toc >= sfr_pkg::TOC_TIMED_MIN;
  wire [13:0] toc = fl_cfg_ff.fastlock_timeout_count;
  wire timed_mode = toc >= sfr_pkg::TOC_TIMED_MIN;
  wire [sfr_pkg::PERIOD_W-1:0] nxt_period = {new_toc, 1'b0};
  wire fl_last = fl_active_ff && main_comp_tick_in && (remain_ff == 15'h0001);
  wire ce_rise = ce_sync_ff[1] & ~ce_sync_ff[2];
  wire powerup_event = ce_rise | soft_powerup_in;

  // Register loads; fixed-pattern bits of the reset word are ignored
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      fl_cfg_ff <= sfr_pkg::FASTLOCK_RESET;
      lr_cfg_ff <= sfr_pkg::LOOP_RESET_RESET;
    end else begin
      if (wr_fastlock) fl_cfg_ff <= rx_word[WORD_W-1:sfr_pkg::TOC_LSB];
      if (wr_loop_reset) lr_cfg_ff <= {rx_word[sfr_pkg::QUARTER_POS],
                                       rx_word[sfr_pkg::AUX_CLEAR_POS:sfr_pkg::MAIN_FLOAT_POS]};
    end
  end

  // Timed fastlock: each new fastlock word with a timed code restarts the period, a lower code stops it
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      fl_active_ff <= 1'b0;
      remain_ff <= '0;
    end else if (wr_fastlock) begin
      fl_active_ff <= new_timed;
      remain_ff <= new_timed ? nxt_period : '0;
    end else if (fl_active_ff && main_comp_tick_in) begin
      remain_ff <= remain_ff - 15'h0001;
      if (fl_last) fl_active_ff <= 1'b0;
    end
  end

  // Pin function from the time-out code; registered to keep the pin glitch free
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pin_level_ff <= 1'b0;
      pin_oe_n_ff <= 1'b1;
    end else begin
      pin_oe_n_ff <= (toc == sfr_pkg::TOC_FLOAT);
      pin_level_ff <= timed_mode ? fl_active_ff : (toc == sfr_pkg::TOC_HIGH);
    end
  end

  // Enable pin synchroniser; power-up clear held until the next comparison tick
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ce_sync_ff <= 3'h7; // Reset to idle high: an enable held high gives no false edge
      powerup_clear_ff <= 1'b1;
    end else begin
      ce_sync_ff <= {ce_sync_ff[1:0], chip_enable_in};
      if (powerup_event) powerup_clear_ff <= 1'b1;
      else if (main_comp_tick_in) powerup_clear_ff <= 1'b0;
    end
  end

  // Lock-detect quarter-rate divider, main loop only
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) qdiv_ff <= 2'h0;
    else if (main_comp_tick_in) qdiv_ff <= qdiv_ff + 2'h1;
  end

  // Denominator select: upper field is masked, not trusted, in 12-bit mode
  assign main_fraction_denominator_out = precision_sel_in ?
    {den_hi_in, den_lo_in} : {{sfr_pkg::DEN_HI_W{1'b0}}, den_lo_in};
  assign fastlock_force_out = (toc == sfr_pkg::TOC_MANUAL);
  assign fastlock_active_out = fl_active_ff | fastlock_force_out;
  assign fastlock_pin_out = pin_level_ff;
  assign fastlock_pin_oe_n_out = pin_oe_n_ff;
  assign pump_gain_mult_out = fastlock_active_out ?
    ({1'b0, fl_cfg_ff.fastlock_pump_gain} + 5'h01) : 5'h01;
  assign slip_div_log2_out = slip_log2(fl_cfg_ff.slip_reduction_factor);
  assign main_ld_tick_out = main_comp_tick_in &&
    (!lr_cfg_ff.lock_detect_quarter_rate || qdiv_ff == sfr_pkg::QDIV_LAST);
  assign aux_ld_tick_out = aux_comp_tick_in;
  assign main_counters_reset_out = lr_cfg_ff.main_loop_counter_clear | powerup_clear_ff;
  assign aux_counters_reset_out = lr_cfg_ff.aux_counter_clear | powerup_clear_ff;
  assign main_pump_tristate_out = main_counters_reset_out | lr_cfg_ff.main_pump_float_bit;
  assign aux_pump_tristate_out = aux_counters_reset_out | lr_cfg_ff.aux_pump_float;

  // Checks on the decoded behaviour
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!resetn_in);

  a_den_short_mode: assert property (!precision_sel_in |->
    main_fraction_denominator_out == {10'h000, den_lo_in}) else $error("12-bit den wrong");
  a_den_full_mode: assert property (precision_sel_in |->
    main_fraction_denominator_out == {den_hi_in, den_lo_in}) else $error("22-bit den wrong");
  a_low_codes_off: assert property (!timed_mode |-> !fl_active_ff)
    else $error("fastlock timer runs with low code");
  a_timed_start: assert property (wr_fastlock && new_timed |=>
    fl_active_ff && remain_ff == {$past(new_toc), 1'b0}) else $error("fastlock start wrong");
  a_timed_end: assert property (fl_last && !wr_fastlock |=>
    !fl_active_ff && remain_ff == 15'h0) else $error("fastlock end wrong");
  a_pin_float: assert property (toc == sfr_pkg::TOC_FLOAT && !wr_fastlock |=>
    fastlock_pin_oe_n_out) else $error("pin not floating");
  a_pin_high: assert property (toc == sfr_pkg::TOC_HIGH && !wr_fastlock |=>
    !fastlock_pin_oe_n_out && fastlock_pin_out) else $error("pin not high");
  a_pin_low: assert property (toc == sfr_pkg::TOC_LOW && !wr_fastlock |=>
    !fastlock_pin_oe_n_out && !fastlock_pin_out) else $error("pin not low");
  a_pin_manual: assert property (toc == sfr_pkg::TOC_MANUAL && !wr_fastlock |=>
    !fastlock_pin_oe_n_out && !fastlock_pin_out && fastlock_force_out)
    else $error("manual pin wrong");
  a_pin_timed: assert property (timed_mode && !wr_fastlock |=>
    fastlock_pin_out == $past(fl_active_ff)) else $error("pin not fastlock");
  a_gain_map: assert property (fastlock_active_out |->
    pump_gain_mult_out == fl_cfg_ff.fastlock_pump_gain + 5'h01) else $error("gain map");
  a_gain_idle: assert property (!fastlock_active_out |-> pump_gain_mult_out == 5'h01)
    else $error("gain not 1X outside fastlock");
  a_slip_top: assert property (fl_cfg_ff.slip_reduction_factor == 2'h3 |->
    slip_div_log2_out == 3'h4) else $error("slip 1/16 wrong");
  a_slip_half: assert property (fl_cfg_ff.slip_reduction_factor == 2'h1 |->
    slip_div_log2_out == 3'h1) else $error("slip 1/2 wrong");
  a_quarter_rate: assert property (
    lr_cfg_ff.lock_detect_quarter_rate && main_ld_tick_out |=> !main_ld_tick_out [*3])
    else $error("quarter rate too fast");
  a_quarter_off: assert property (!lr_cfg_ff.lock_detect_quarter_rate |->
    main_ld_tick_out == main_comp_tick_in) else $error("full rate tick lost");
  a_aux_tick_pass: assert property (aux_ld_tick_out == aux_comp_tick_in)
    else $error("aux tick changed");
  a_aux_clear: assert property (lr_cfg_ff.aux_counter_clear |->
    aux_counters_reset_out && aux_pump_tristate_out) else $error("aux clear");
  a_main_clear: assert property (lr_cfg_ff.main_loop_counter_clear |->
    main_counters_reset_out && main_pump_tristate_out) else $error("main clear");
  a_powerup_reset: assert property (soft_powerup_in |=>
    main_counters_reset_out && aux_counters_reset_out) else $error("powerup reset missing");
  a_float_counts: assert property (
    lr_cfg_ff.main_pump_float_bit && !lr_cfg_ff.main_loop_counter_clear && !powerup_clear_ff
    |-> main_pump_tristate_out && !main_counters_reset_out) else $error("float bit ignored");
  a_route_word: assert property (rx_valid && rx_addr == sfr_pkg::ADDR_FASTLOCK |=>
    fl_cfg_ff == $past(rx_word[WORD_W-1:sfr_pkg::TOC_LSB])) else $error("route wrong");

  c_timed_done: cover property (fl_active_ff ##1 !fl_active_ff);
  c_manual: cover property (fastlock_force_out);
  c_quarter: cover property (lr_cfg_ff.lock_detect_quarter_rate && main_ld_tick_out);
  c_reset_word: cover property (wr_loop_reset);
  c_float_only: cover property (main_pump_tristate_out && !main_counters_reset_out);
endmodule : sfr_fastlock_reset_control

// ==== sfr_host_model.sv ====
`timescale 1ns/10ps
// Host side of the three-wire port; pins only move on the falling edge
module sfr_host_model #(
  parameter int HOLD = 4
) (
  input wire logic clock_in,
  output logic ser_clk_out,
  output logic ser_data_out,
  output logic ser_latch_out
);
  initial begin
    ser_clk_out = 1'b0;
    ser_data_out = 1'b0;
    ser_latch_out = 1'b0;
  end

  // Each level held HOLD cycles, the sync needs at least three
  task automatic send_word(input logic [23:0] w);
    for (int i = 23; i >= 0; i--) begin
      ser_data_out = w[i];
      repeat (HOLD) @(negedge clock_in);
      ser_clk_out = 1'b1;
      repeat (HOLD) @(negedge clock_in);
      ser_clk_out = 1'b0;
    end
    // Data line driven to the complement of the last bit; shift clock idles low
    ser_data_out = ~w[0];
    ser_latch_out = 1'b1;
    repeat (HOLD) @(negedge clock_in);
    ser_latch_out = 1'b0;
    repeat (2 * HOLD) @(negedge clock_in);
  endtask : send_word
endmodule : sfr_host_model

// ==== sfr_pkg.sv ====
package sfr_pkg;
  // Serial word geometry
  localparam int WORD_W = 24;
  localparam int ADDR_W = 4;
  localparam logic [3:0] ADDR_FASTLOCK = 4'b1101;
  localparam logic [3:0] ADDR_LOOP_RESET = 4'b1111;
  // Fastlock word field positions
  localparam int TOC_LSB = 4;
  localparam int TOC_W = 14;
  localparam int GAIN_LSB = 18;
  localparam int GAIN_W = 4;
  localparam int SLIP_LSB = 22;
  localparam int SLIP_W = 2;
  // Loop reset word bit positions
  localparam int MAIN_FLOAT_POS = 4;
  localparam int AUX_FLOAT_POS = 5;
  localparam int MAIN_CLEAR_POS = 6;
  localparam int AUX_CLEAR_POS = 7;
  localparam int QUARTER_POS = 13;
  // Denominator widths
  localparam int DEN_LO_W = 12;
  localparam int DEN_HI_W = 10;
  localparam int DEN_W = 22;
  // Time-out code meanings
  localparam logic [13:0] TOC_FLOAT = 14'h0000;
  localparam logic [13:0] TOC_MANUAL = 14'h0001;
  localparam logic [13:0] TOC_LOW = 14'h0002;
  localparam logic [13:0] TOC_HIGH = 14'h0003;
  localparam logic [13:0] TOC_TIMED_MIN = 14'h0004;
  localparam int PERIOD_W = 15;
  // Quarter-rate divider last count; reset values follow the types
  localparam logic [1:0] QDIV_LAST = 2'h3;

  typedef struct packed {
    logic [1:0] slip_reduction_factor;
    logic [3:0] fastlock_pump_gain;
    logic [13:0] fastlock_timeout_count;
  } sfr_fastlock_t;

  typedef struct packed {
    logic lock_detect_quarter_rate;
    logic aux_counter_clear;
    logic main_loop_counter_clear;
    logic aux_pump_float;
    logic main_pump_float_bit;
  } sfr_loop_reset_t;

  localparam sfr_fastlock_t FASTLOCK_RESET = '0;
  localparam sfr_loop_reset_t LOOP_RESET_RESET = '0;
endpackage : sfr_pkg

// ==== sfr_serial_rx.sv ====
`timescale 1ns/10ps
module sfr_serial_rx #(
  parameter int WORD_W = 24
) (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic ser_clk_in,
  input wire logic ser_data_in,
  input wire logic ser_latch_in,
  output logic [WORD_W-1:0] word_out,
  output logic word_valid_out
);
  logic [2:0] clk_sync_ff;
  logic [1:0] data_sync_ff;
  logic [2:0] latch_sync_ff;
  logic [WORD_W-1:0] shift_ff;
  logic [WORD_W-1:0] word_ff;
  logic valid_ff;
  wire clk_rise = clk_sync_ff[1] & ~clk_sync_ff[2];
  wire latch_rise = latch_sync_ff[1] & ~latch_sync_ff[2];

  // Pins are asynchronous: two stages before any edge detect
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      clk_sync_ff <= 3'h0;
      data_sync_ff <= 2'h0;
      latch_sync_ff <= 3'h0;
    end else begin
      clk_sync_ff <= {clk_sync_ff[1:0], ser_clk_in};
      data_sync_ff <= {data_sync_ff[0], ser_data_in};
      latch_sync_ff <= {latch_sync_ff[1:0], ser_latch_in};
    end
  end

  // MSB first; the last 24 bits before the latch edge form the word
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      shift_ff <= '0;
      word_ff <= '0;
      valid_ff <= 1'b0;
    end else begin
      if (clk_rise) shift_ff <= {shift_ff[WORD_W-2:0], data_sync_ff[1]};
      if (latch_rise) word_ff <= shift_ff;
      valid_ff <= latch_rise;
    end
  end

  assign word_out = word_ff;
  assign word_valid_out = valid_ff;
endmodule : sfr_serial_rx

// ==== tb.sv ====
`timescale 1ns/10ps
module tb;
  logic clock_in, resetn_in, sclk, sdat, slat, ce, soft_pu, mtick, atick, psel;
  logic [11:0] den_lo;
  logic [9:0] den_hi;
  logic [21:0] den;
  logic act, force_fl, pin, oe_n, m_ld, a_ld, m_crst, m_tri, a_crst, a_tri;
  logic [4:0] gmul;
  logic [2:0] slip;
  logic [3:0] gf;
  logic [4:0] rb;
  int errors, num_checks, seen, t;

  sfr_host_model u_sfr_host_model (.clock_in(clock_in), .ser_clk_out(sclk),
    .ser_data_out(sdat), .ser_latch_out(slat));
  sfr_fastlock_reset_control u_sfr_fastlock_reset_control (.clock_in(clock_in),
    .resetn_in(resetn_in), .ser_clk_in(sclk), .ser_data_in(sdat), .ser_latch_in(slat),
    .chip_enable_in(ce), .soft_powerup_in(soft_pu), .main_comp_tick_in(mtick),
    .aux_comp_tick_in(atick), .precision_sel_in(psel), .den_lo_in(den_lo),
    .den_hi_in(den_hi), .main_fraction_denominator_out(den), .fastlock_active_out(act),
    .fastlock_force_out(force_fl), .fastlock_pin_out(pin), .fastlock_pin_oe_n_out(oe_n),
    .pump_gain_mult_out(gmul), .slip_div_log2_out(slip), .main_ld_tick_out(m_ld),
    .aux_ld_tick_out(a_ld), .main_counters_reset_out(m_crst),
    .main_pump_tristate_out(m_tri), .aux_counters_reset_out(a_crst),
    .aux_pump_tristate_out(a_tri));

  // Expected slip output is log2 of the divisor
  function automatic logic [2:0] exp_slip(input logic [1:0] c);
    return (c == 2'h3) ? 3'h4 : {1'b0, c};
  endfunction : exp_slip

  task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %0h seen %0h", name, exp, got);
    end
  endtask : check

  task automatic print_verdict;
    if (errors == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict

  // Comparison ticks with a gap; counts the lock-detect pulses let through
  task automatic ticks(input int n, input logic aux);
    for (int i = 0; i < n; i++) begin
      mtick = 1'b1;
      atick = aux;
      #1;
      seen += int'(m_ld);
      check("aux_ld", a_ld, aux);
      @(negedge clock_in);
      mtick = 1'b0;
      atick = 1'b0;
      @(negedge clock_in);
    end
  endtask : ticks

  initial begin
    clock_in = 1'b0;
    forever #10 clock_in = ~clock_in;
  end

  // Watchdog so a stuck run still reaches the verdict
  initial begin
    repeat (100000) @(posedge clock_in);
    errors++;
    print_verdict();
  end

  initial begin
    errors = 0;
    num_checks = 0;
    seen = 0;
    {resetn_in, soft_pu, mtick, atick, psel, den_lo, den_hi} = '0;
    ce = 1'b1;
    void'($urandom(37));
    repeat (10) @(negedge clock_in);
    resetn_in = 1'b1;
    @(negedge clock_in);
    check("m_crst", m_crst, 1);
    check("a_tri", a_tri, 1);
    check("oe_n", oe_n, 1);
    ticks(1, 1'b0);
    check("m_crst", m_crst, 0);
    // Denominator in both precisions, upper bits random to prove masking
    for (int i = 0; i < 16; i++) begin
      psel = i[0];
      den_lo = 12'($urandom);
      den_hi = (psel || i[1]) ? 10'($urandom) : 10'h000;
      #1;
      check("den", den, psel ? {den_hi, den_lo} : {10'h000, den_lo});
      @(negedge clock_in);
    end
    // Static pin codes, each with its own slip code
    for (int c = 0; c < 4; c++) begin
      gf = 4'($urandom);
      u_sfr_host_model.send_word({c[1:0], gf, c[13:0], sfr_pkg::ADDR_FASTLOCK});
      check("slip", slip, exp_slip(c[1:0]));
      check("act", act, c == 1);
      check("force", force_fl, c == 1);
      check("oe_n", oe_n, c == 0);
      check("pin", pin, c == 3);
      check("gain", gmul, (c == 1) ? gf + 5'h01 : 5'h01);
    end
    // Timed fastlock: lower boundary then a random code
    for (int k = 0; k < 2; k++) begin
      t = (k == 0) ? 4 : 4 + $urandom_range(0, 8);
      gf = 4'($urandom);
      u_sfr_host_model.send_word({2'b00, gf, 14'(t), sfr_pkg::ADDR_FASTLOCK});
      check("act", act, 1);
      check("pin", {oe_n, pin}, 2'b01);
      check("gain", gmul, gf + 5'h01);
      ticks(2 * t - 1, 1'b0);
      check("act", act, 1);
      ticks(1, 1'b0);
      repeat (2) @(negedge clock_in);
      check("act", act, 0);
      check("pin", pin, 0);
    end
    // Word at an unknown address leaves the slip code alone
    u_sfr_host_model.send_word({2'b11, 4'hf, 14'h0003, 4'h0});
    check("slip", slip, 0);
    // Loop reset word; pass 0 float-only, pass 1 quarter rate, fixed pattern in unnamed bits
    for (int i = 0; i < 6; i++) begin
      rb = (i == 0) ? 5'h01 : (i == 1) ? 5'h10 : 5'($urandom);
      u_sfr_host_model.send_word({10'h000, rb[4], 2'b01, 3'h0, rb[3:0], 4'hf});
      check("m_crst", m_crst, rb[2]);
      check("a_crst", a_crst, rb[3]);
      check("m_tri", m_tri, rb[2] | rb[0]);
      check("a_tri", a_tri, rb[3] | rb[1]);
      seen = 0;
      ticks(8, 1'b1);
      check("m_ld", seen, rb[4] ? 2 : 8);
    end
    u_sfr_host_model.send_word({10'h000, 1'b0, 2'b01, 3'h0, 4'h0, 4'hf});
    // Software and enable-pin power-up both clear the counters
    soft_pu = 1'b1;
    @(negedge clock_in);
    soft_pu = 1'b0;
    check("m_crst", m_crst, 1);
    ticks(1, 1'b0);
    check("m_crst", m_crst, 0);
    ce = 1'b0;
    repeat (5) @(negedge clock_in);
    ce = 1'b1;
    repeat (5) @(negedge clock_in);
    check("a_crst", a_crst, 1);
    // Mid-run reset puts every field back to its default
    u_sfr_host_model.send_word({2'b11, 4'h5, 14'h0002, sfr_pkg::ADDR_FASTLOCK});
    check("slip", slip, exp_slip(2'h3));
    resetn_in = 1'b0;
    repeat (2) @(negedge clock_in);
    resetn_in = 1'b1;
    @(negedge clock_in);
    check("slip", slip, 0);
    check("oe_n", oe_n, 1);
    check("m_tri", m_tri, 1);
    ticks(1, 1'b0);
    check("m_crst", m_crst, 0);
    print_verdict();
  end
endmodule : tb
